//--- core/bsr_exec.sv
// Contract
// (RULE1) clear-carry zeroes carry, other flags kept
// (RULE2) set-carry sets carry, other flags kept
// (RULE3) bit-clear zeroes selected destination bit
// (RULE4) bit-set sets bit; status: only C, E
// (RULE5) bit ops only on modules 8, 0-5
// (RULE6) negate: invert plus one, sign zero
// (RULE7) or: acc or source, sign zero
// (RULE8) 8-bit source upper byte from prefix
// (RULE9) software never uses acc as or source
// (RULE10) carry ors with chosen accumulator bit
// (RULE11) 8-bit variant: bit index 0-7 only
// (RULE12) pop reads top then decrements pointer
// (RULE13) rearming pop also clears in-service flag
// (RULE14) push increments pointer then stores word
// (RULE15) return loads pointer from stack, decrements
// (RULE16) conditional return on five flag tests
// (RULE17) interrupt return also clears in-service
// (RULE18) conditional interrupt return, same five tests
// (RULE19) rotate left, msb into bit 0, sign
// (RULE20) rotate left through carry, carry sign zero
// (RULE21) rotate right, plain and through carry
// (RULE22) copy selected source bit into carry
// (RULE23) sign is msb, zero means all zero
`timescale 1ns/1ps
module bsr_exec import bsr_pkg::*; #(
  parameter int unsigned ACC_W = 16,
  parameter int unsigned STK_AW = 4
) (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic irq_ack, // interrupt acknowledged, sets in-service
  output logic interrupt_in_service_flag, // in-service state
  output logic [15:0] instruction_pointer // current pointer
);
  logic [ACC_W-1:0] acc, next_acc, res, opnd;
  bsr_flags_s flg, next_flg;
  logic [STK_AW-1:0] stack_pointer, next_sp;
  logic [15:0] next_ip, src_reg, opnd16, acc16, st_rdata, st_wdata;
  logic [7:0] prefix_register, mod_q, mod_wdata;
  logic [6:0] msel, dst;
  logic [7:0] mreg [0:127];
  logic [31:0] rd_mux;
  logic acc_op, wr, exec, st_we, mod_we, ins_clr, taken, unk, next_unk;
  logic [15:0] ir;
  bsr_op_e op;

  function automatic logic [6:0] mod_idx(input logic [6:0] d);
    return {d[3:0], d[6:4]};
  endfunction

  function automatic logic mod_ok(input logic [6:0] d);
    return d[3:0] == MOD_SYS || d[3:0] <= MOD_PERIPH_MAX;
  endfunction

  // apb slave, zero wait states while enabled
  assign pready = ce;
  assign wr = psel && penable && pwrite && ce;
  assign exec = wr && paddr == OFF_INSTR;
  assign ir = pwdata[15:0];
  assign dst = ir[14:8];
  assign acc16 = 16'(acc);
  assign mod_q = mreg[mod_idx(dst)];

  always_comb begin
    unique case (paddr)
      OFF_INSTR, OFF_ACC, OFF_FLAGS, OFF_SP, OFF_IP, OFF_PFX, OFF_SRC,
      OFF_MSEL, OFF_MDATA: pslverr = psel && penable;
      default: pslverr = psel && penable && ce;
    endcase
    if (paddr == OFF_INSTR || paddr == OFF_ACC || paddr == OFF_FLAGS ||
        paddr == OFF_SP || paddr == OFF_IP || paddr == OFF_PFX ||
        paddr == OFF_SRC || paddr == OFF_MSEL || paddr == OFF_MDATA) begin
      pslverr = 1'b0;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFF_ACC: rd_mux = 32'(acc);
      OFF_FLAGS: begin
        rd_mux[3:0] = flg;
        rd_mux[INS_BIT] = interrupt_in_service_flag;
        rd_mux[UNK_BIT] = unk;
      end
      OFF_SP: rd_mux = 32'(stack_pointer);
      OFF_IP: rd_mux = 32'(instruction_pointer);
      OFF_PFX: rd_mux = 32'(prefix_register);
      OFF_SRC: rd_mux = 32'(src_reg);
      OFF_MSEL: rd_mux = 32'(msel);
      OFF_MDATA: rd_mux = mod_ok(msel) ? 32'(mreg[mod_idx(msel)]) : '0;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data is caught in the setup cycle so it stands as a flop output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  // decode, first match wins
  always_comb begin
    if (ir == OPC_CLRC) op = OP_CLRC;
    else if (ir == OPC_SETC) op = OP_SETC;
    else if (ir == OPC_NEG) op = OP_NEG;
    else if (ir == OPC_RL) op = OP_RL;
    else if (ir == OPC_RLC) op = OP_RLC;
    else if (ir == OPC_RR) op = OP_RR;
    else if (ir == OPC_RRC) op = OP_RRC;
    else if ((ir & ORC_MASK) == ORC_PAT) op = OP_ORC;
    else if (ir[14:8] == OR_PAT) op = OP_OR;
    else if (ir[14:8] == PUSH_PAT) op = OP_PUSH;
    else if (ir[15] && ir[11:8] == RET_DST && ir[6:0] == STK_LOW) op = OP_RET;
    else if (ir[15] && ir[6:0] == STK_LOW) op = OP_POP;
    else if (ir[11:8] == BIT_LOW) op = OP_CBIT;
    else if (ir[15] && ir[3:0] == BIT_LOW) begin
      op = ir[7] ? OP_BITSET : OP_BITCLR;
    end else op = OP_NONE;
  end

  // immediate source gets its upper byte from the prefix
  assign opnd16 = ir[15] ? src_reg : {prefix_register, ir[7:0]}; // see RULE8
  assign opnd = opnd16[ACC_W-1:0];

  always_comb begin
    unique case (ir[14:12])
      CND_ALWAYS: taken = 1'b1;
      CND_C: taken = flg.c;
      CND_NC: taken = !flg.c;
      CND_Z: taken = flg.z;
      CND_NZ: taken = !flg.z;
      CND_S: taken = flg.s;
      default: taken = 1'b0;
    endcase
  end

  always_comb begin
    next_acc = acc;
    next_flg = flg;
    next_sp = stack_pointer;
    next_ip = instruction_pointer + 16'h0001;
    next_unk = 1'b0;
    res = acc;
    acc_op = 1'b0;
    st_we = 1'b0;
    st_wdata = opnd16;
    mod_we = 1'b0;
    mod_wdata = mod_q;
    ins_clr = 1'b0;
    unique case (op)
      OP_NONE: next_unk = 1'b1;
      OP_CLRC: next_flg.c = 1'b0; // see RULE1
      OP_SETC: next_flg.c = 1'b1; // see RULE2
      OP_BITCLR, OP_BITSET: begin
        if (dst == DST_PSF) begin
          // only carry and e are writable status bits
          if ({1'b0, ir[6:4]} == FLG_C_BIT) next_flg.c = ir[7]; // see RULE4
          if ({1'b0, ir[6:4]} == FLG_E_BIT) next_flg.e = ir[7]; // see RULE4
        end else if (mod_ok(dst)) begin // see RULE5
          mod_we = 1'b1;
          mod_wdata[ir[6:4]] = ir[7]; // see RULE3, RULE4
        end
      end
      OP_NEG: begin
        res = ~acc + 1'b1; // see RULE6
        acc_op = 1'b1;
      end
      OP_OR: begin
        res = acc | opnd; // see RULE7
        acc_op = 1'b1;
      end
      OP_ORC: begin
        if (ir[7:4] < ACC_W) begin // see RULE11
          next_flg.c = flg.c | acc16[ir[7:4]]; // see RULE10
        end
      end
      OP_POP: begin
        next_sp = stack_pointer - 1'b1; // see RULE12
        ins_clr = ir[7]; // see RULE13
        if (dst == DST_ACC) begin
          next_acc = st_rdata[ACC_W-1:0];
          next_flg.s = st_rdata[ACC_W-1]; // see RULE23
          next_flg.z = st_rdata[ACC_W-1:0] == '0;
        end else if (dst == DST_PSF) begin
          next_flg.c = st_rdata[FLG_C_BIT];
          next_flg.e = st_rdata[FLG_E_BIT];
        end else if (mod_ok(dst)) begin
          mod_we = 1'b1;
          mod_wdata = st_rdata[7:0];
        end
      end
      OP_PUSH: begin
        next_sp = stack_pointer + 1'b1; // see RULE14
        st_we = 1'b1;
      end
      OP_RET: begin
        if (taken) begin // see RULE16, RULE18
          next_ip = st_rdata; // see RULE15
          next_sp = stack_pointer - 1'b1;
          ins_clr = ir[7]; // see RULE17
        end
      end
      OP_RL: begin
        next_acc = {acc[ACC_W-2:0], acc[ACC_W-1]}; // see RULE19
        next_flg.s = acc[ACC_W-2];
      end
      OP_RLC: begin
        res = {acc[ACC_W-2:0], flg.c}; // see RULE20
        next_flg.c = acc[ACC_W-1];
        acc_op = 1'b1;
      end
      OP_RR: begin
        next_acc = {acc[0], acc[ACC_W-1:1]}; // see RULE21
        next_flg.s = acc[0];
      end
      OP_RRC: begin
        res = {flg.c, acc[ACC_W-1:1]}; // see RULE21
        next_flg.c = acc[0];
        acc_op = 1'b1;
      end
      OP_CBIT: next_flg.c = src_reg[ir[15:12]]; // see RULE22
    endcase
    if (acc_op) begin
      next_acc = res;
      next_flg.s = res[ACC_W-1]; // see RULE23
      next_flg.z = res == '0; // see RULE23
    end
  end

  bsr_stack #(.AW(STK_AW)) u_stack (
    .pclk(pclk),
    .ce(ce),
    .we(exec && st_we),
    .waddr(next_sp),
    .wdata(st_wdata),
    .raddr(stack_pointer),
    .rdata(st_rdata)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= '0;
      flg <= FLAGS_RST;
      unk <= 1'b0;
    end else if (exec) begin
      acc <= next_acc;
      flg <= next_flg;
      unk <= next_unk;
    end else if (wr && paddr == OFF_ACC) begin
      acc <= pwdata[ACC_W-1:0];
    end else if (wr && paddr == OFF_FLAGS) begin
      flg <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_pointer <= '0;
      instruction_pointer <= IP_RST;
    end else if (exec) begin
      stack_pointer <= next_sp;
      instruction_pointer <= next_ip;
    end else if (wr && paddr == OFF_SP) begin
      stack_pointer <= pwdata[STK_AW-1:0];
    end else if (wr && paddr == OFF_IP) begin
      instruction_pointer <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prefix_register <= PFX_RST;
      src_reg <= 16'h0000;
      msel <= 7'h00;
    end else if (wr) begin
      if (paddr == OFF_PFX) prefix_register <= pwdata[7:0];
      if (paddr == OFF_SRC) src_reg <= pwdata[15:0];
      if (paddr == OFF_MSEL) msel <= pwdata[6:0];
    end
  end

  // module register bank, only supported modules are ever written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 128; i++) mreg[i] <= 8'h00;
    end else if (exec && mod_we) begin
      mreg[mod_idx(dst)] <= mod_wdata;
    end else if (wr && paddr == OFF_MDATA && mod_ok(msel)) begin
      mreg[mod_idx(msel)] <= pwdata[7:0];
    end
  end

  // acknowledge wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_in_service_flag <= 1'b0;
    end else if (ce) begin
      if (irq_ack) interrupt_in_service_flag <= 1'b1;
      else if (exec && ins_clr) interrupt_in_service_flag <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_run(logic [15:0] c);
    exec && ir == c;
  endsequence

  a_clrc_flags: assert property (s_run(OPC_CLRC) |=> // see RULE1
    !flg.c && flg.s == $past(flg.s) && flg.z == $past(flg.z))
    else $error("clear carry wrong");
  a_setc_flags: assert property (s_run(OPC_SETC) |=> // see RULE2
    flg.c && flg.e == $past(flg.e) && acc == $past(acc))
    else $error("set carry wrong");
  a_neg_value: assert property (s_run(OPC_NEG) |=> // see RULE6
    acc == ACC_W'(~$past(acc) + 1'b1) && flg.s == acc[ACC_W-1])
    else $error("negate wrong");
  a_rl_value: assert property (s_run(OPC_RL) |=> // see RULE19
    acc[0] == $past(acc[ACC_W-1]) && flg.z == $past(flg.z))
    else $error("rotate left wrong");
  a_rlc_carry: assert property (s_run(OPC_RLC) |=> // see RULE20
    flg.c == $past(acc[ACC_W-1]) && acc[0] == $past(flg.c))
    else $error("rotate through carry wrong");
  a_push_pointer: assert property (exec && op == OP_PUSH |=> // see RULE14
    stack_pointer == STK_AW'($past(stack_pointer) + 1'b1))
    else $error("push pointer wrong");
  a_pop_pointer: assert property (exec && op == OP_POP |=> // see RULE12
    stack_pointer == STK_AW'($past(stack_pointer) - 1'b1))
    else $error("pop pointer wrong");
  a_interrupt_exit_op_clear: assert property (exec && ir == OPC_INTERRUPT_EXIT_OP && !irq_ack |=> // see RULE17
    !interrupt_in_service_flag)
    else $error("interrupt return kept in-service");
  a_ret_skip: assert property (exec && op == OP_RET && !taken |=> // see RULE16
    instruction_pointer == $past(instruction_pointer) + 16'h0001 &&
    $stable(stack_pointer))
    else $error("untaken return moved stack");
  a_orc_carry: assert property (exec && op == OP_ORC && flg.c |=> // see RULE10
    flg.c)
    else $error("carry or lost carry");
endmodule // bsr_exec

//--- core/bsr_pkg.sv
// shared constants and types of the bit, stack and rotate execution unit
package bsr_pkg;
  // apb byte offsets
  localparam logic [11:0] OFF_INSTR = 12'h000;
  localparam logic [11:0] OFF_ACC = 12'h004;
  localparam logic [11:0] OFF_FLAGS = 12'h008;
  localparam logic [11:0] OFF_SP = 12'h00C;
  localparam logic [11:0] OFF_IP = 12'h010;
  localparam logic [11:0] OFF_PFX = 12'h014;
  localparam logic [11:0] OFF_SRC = 12'h018;
  localparam logic [11:0] OFF_MSEL = 12'h01C;
  localparam logic [11:0] OFF_MDATA = 12'h020;
  // exact opcodes
  localparam logic [15:0] OPC_CLRC = 16'hDA0A;
  localparam logic [15:0] OPC_SETC = 16'hDA1A;
  localparam logic [15:0] OPC_NEG = 16'h8A9A;
  localparam logic [15:0] OPC_RL = 16'h8A4A;
  localparam logic [15:0] OPC_RLC = 16'h8A5A;
  localparam logic [15:0] OPC_RR = 16'h8ACA;
  localparam logic [15:0] OPC_RRC = 16'h8ADA;
  localparam logic [15:0] OPC_RET = 16'h8C0D;
  localparam logic [15:0] OPC_INTERRUPT_EXIT_OP = 16'h8C8D;
  // opcode patterns
  localparam logic [15:0] ORC_MASK = 16'hFF0F;
  localparam logic [15:0] ORC_PAT = 16'hAA0A;
  localparam logic [6:0] OR_PAT = 7'h2A;
  localparam logic [6:0] PUSH_PAT = 7'h0D;
  localparam logic [6:0] STK_LOW = 7'h0D;
  localparam logic [3:0] RET_DST = 4'hC;
  localparam logic [3:0] BIT_LOW = 4'h7;
  // destination codes and supported modules
  localparam logic [6:0] DST_ACC = 7'h0A;
  localparam logic [6:0] DST_PSF = 7'h48;
  localparam logic [3:0] MOD_SYS = 4'h8;
  localparam logic [3:0] MOD_PERIPH_MAX = 4'h5;
  // return conditions
  localparam logic [2:0] CND_ALWAYS = 3'h0;
  localparam logic [2:0] CND_C = 3'h2;
  localparam logic [2:0] CND_NC = 3'h6;
  localparam logic [2:0] CND_Z = 3'h1;
  localparam logic [2:0] CND_NZ = 3'h5;
  localparam logic [2:0] CND_S = 3'h4;
  // flag bit positions within the status register
  localparam logic [3:0] FLG_C_BIT = 4'h0;
  localparam logic [3:0] FLG_E_BIT = 4'h3;
  localparam int unsigned INS_BIT = 4;
  localparam int unsigned UNK_BIT = 5;
  // reset values
  localparam logic [15:0] IP_RST = 16'h0000;
  localparam logic [7:0] PFX_RST = 8'h00;

  typedef struct packed {
    logic e;
    logic z;
    logic s;
    logic c;
  } bsr_flags_s;

  localparam bsr_flags_s FLAGS_RST = '{e: 1'b0, z: 1'b0, s: 1'b0, c: 1'b0};

  typedef enum logic [3:0] {
    OP_NONE, OP_CLRC, OP_SETC, OP_BITCLR, OP_BITSET, OP_NEG, OP_OR,
    OP_ORC, OP_POP, OP_PUSH, OP_RET, OP_RL, OP_RLC, OP_RR, OP_RRC, OP_CBIT
  } bsr_op_e;
endpackage

//--- core/bsr_stack.sv
// word-wide stack memory, synchronous write and combinational read
`timescale 1ns/1ps
module bsr_stack import bsr_pkg::*; #(
  parameter int unsigned AW = 4
) (
  input wire logic pclk, // core clock
  input wire logic ce, // clock enable
  input wire logic we, // write strobe
  input wire logic [AW-1:0] waddr, // write address
  input wire logic [15:0] wdata, // write word
  input wire logic [AW-1:0] raddr, // read address
  output logic [15:0] rdata // word at read address
);
  logic [15:0] mem [0:(1<<AW)-1];

  always_ff @(posedge pclk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule // bsr_stack

//--- test/bsr_exec_tb_top.sv
// self-checking bench for the bit, stack and rotate execution unit
`timescale 1ns/1ps
module bsr_exec_tb_top import bsr_pkg::*;;
  logic pclk;
  logic presetn;
  logic ce;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_ack;
  logic interrupt_in_service_flag;
  logic [15:0] instruction_pointer;
  int num_errors;
  int num_checks;

  bsr_exec #(.ACC_W(16), .STK_AW(4)) DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_ack(irq_ack),
    .interrupt_in_service_flag(interrupt_in_service_flag),
    .instruction_pointer(instruction_pointer)
  );

  always #12.5 pclk = ~pclk;

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; an idle cycle follows so opcode effects have landed
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    xfer(1'b1, a, d, rd, err);
  endtask

  task automatic op(input logic [15:0] code);
    wr(OFF_INSTR, {16'h0000, code});
  endtask

  task automatic rdchk(input string what, input logic [11:0] a,
                       input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    xfer(1'b0, a, 32'h0000_0000, rd, err);
    chk(what, rd & mask, exp);
  endtask

  task automatic irq_pulse;
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic t_reset;
    logic [11:0] offs[5] = '{OFF_ACC, OFF_FLAGS, OFF_SP, OFF_IP, OFF_PFX};
    logic [31:0] rd;
    logic err;
    foreach (offs[i]) rdchk("reset value", offs[i], 32'hFFFF_FFFF, 32'h0);
    xfer(1'b0, 12'h100, 32'h0, rd, err);
    chk("unmapped error", 32'(err), 32'h1);
    // a frozen core must ignore an acknowledge
    ce <= 1'b0;
    irq_pulse();
    ce <= 1'b1;
    chk("frozen in-service", 32'(interrupt_in_service_flag), 32'h0);
    $display("test reset done");
  endtask

  task automatic t_carry;
    wr(OFF_FLAGS, 32'hE);
    op(OPC_SETC);
    rdchk("set carry", OFF_FLAGS, 32'hF, 32'hF);
    op(OPC_CLRC);
    rdchk("clear carry", OFF_FLAGS, 32'hF, 32'hE);
    op(16'h0000);
    rdchk("unknown opcode", OFF_FLAGS, 32'h2F, 32'h2E);
    $display("test carry done");
  endtask

  task automatic t_neg;
    wr(OFF_ACC, 32'hFEED);
    wr(OFF_FLAGS, 32'h7);
    op(OPC_NEG);
    rdchk("negate acc", OFF_ACC, 32'hFFFF_FFFF, 32'h0113);
    rdchk("negate flags", OFF_FLAGS, 32'hF, 32'h1);
    wr(OFF_ACC, 32'h0);
    wr(OFF_FLAGS, 32'h9);
    op(OPC_NEG);
    rdchk("negate zero", OFF_FLAGS, 32'hF, 32'hD);
    $display("test negate done");
  endtask

  task automatic t_or;
    wr(OFF_PFX, 32'h11);
    wr(OFF_ACC, 32'h2345);
    wr(OFF_FLAGS, 32'h5);
    op(16'h2A33); // immediate source, never the acc itself
    rdchk("or prefix", OFF_ACC, 32'hFFFF_FFFF, 32'h3377);
    rdchk("or flags", OFF_FLAGS, 32'hF, 32'h1);
    wr(OFF_SRC, 32'h0F0F);
    wr(OFF_ACC, 32'h8345);
    op(16'hAA00);
    rdchk("or register", OFF_ACC, 32'hFFFF_FFFF, 32'h8F4F);
    rdchk("or sign", OFF_FLAGS, 32'hF, 32'h3);
    $display("test or done");
  endtask

  task automatic t_orc;
    wr(OFF_ACC, 32'h2345);
    wr(OFF_FLAGS, 32'h0);
    op(16'hAA1A);
    rdchk("carry or bit1", OFF_FLAGS, 32'hF, 32'h0);
    op(16'hAA2A);
    rdchk("carry or bit2", OFF_FLAGS, 32'hF, 32'h1);
    op(16'hAA1A);
    rdchk("carry or keeps", OFF_FLAGS, 32'hF, 32'h1);
    $display("test carry or done");
  endtask

  task automatic t_rot;
    logic [15:0] opc[8] = '{OPC_RL, OPC_RL, OPC_RLC, OPC_RLC, OPC_RLC,
                            OPC_RR, OPC_RRC, OPC_RRC};
    logic [15:0] ain[8] = '{16'hA345, 16'h468B, 16'hA345, 16'h468B,
                            16'h8000, 16'hA345, 16'hA345, 16'hD1A2};
    logic [15:0] aout[8] = '{16'h468B, 16'h8D16, 16'h468B, 16'h8D17,
                             16'h0000, 16'hD1A2, 16'hD1A2, 16'hE8D1};
    logic [3:0] fin[8] = '{4'h4, 4'h0, 4'h1, 4'h1, 4'h0, 4'h4, 4'h1, 4'h1};
    logic [3:0] fout[8] = '{4'h4, 4'h2, 4'h1, 4'h2, 4'h5, 4'h6, 4'h3, 4'h2};
    for (int i = 0; i < 8; i++) begin
      wr(OFF_ACC, 32'(ain[i]));
      wr(OFF_FLAGS, 32'(fin[i]));
      op(opc[i]);
      rdchk("rotate acc", OFF_ACC, 32'hFFFF_FFFF, 32'(aout[i]));
      rdchk("rotate flags", OFF_FLAGS, 32'hF, 32'(fout[i]));
    end
    $display("test rotate done");
  endtask

  task automatic t_stack;
    wr(OFF_PFX, 32'h0);
    wr(OFF_SP, 32'h0);
    wr(OFF_FLAGS, 32'h6);
    op(16'h0D09);
    wr(OFF_SRC, 32'h0F3F);
    op(16'h8D00);
    rdchk("push pointer", OFF_SP, 32'hFFFF_FFFF, 32'h2);
    rdchk("push flags", OFF_FLAGS, 32'hF, 32'h6);
    op(16'h8A0D);
    rdchk("pop acc", OFF_ACC, 32'hFFFF_FFFF, 32'h0F3F);
    rdchk("pop pointer", OFF_SP, 32'hFFFF_FFFF, 32'h1);
    rdchk("pop flags", OFF_FLAGS, 32'hF, 32'h0);
    irq_pulse();
    op(16'hC88D);
    rdchk("rearm pop", OFF_FLAGS, 32'h1F, 32'h09);
    rdchk("rearm pointer", OFF_SP, 32'hFFFF_FFFF, 32'h0);
    chk("rearm port", 32'(interrupt_in_service_flag), 32'h0);
    $display("test stack done");
  endtask

  task automatic t_ret;
    logic [3:0] nib[6] = '{4'h8, 4'hA, 4'hE, 4'h9, 4'hD, 4'hC};
    logic [3:0] fy[6] = '{4'h0, 4'h1, 4'h0, 4'h4, 4'h0, 4'h2};
    logic [3:0] fn[6] = '{4'h0, 4'h0, 4'h1, 4'h0, 4'h4, 4'h0};
    logic [15:0] w;
    logic [15:0] ip0;
    for (int k = 0; k < 6; k++) begin
      for (int ir = 0; ir < 2; ir++) begin
        for (int tk = 1; tk >= 0; tk--) begin
          if (k != 0 || tk != 0) begin
            w = 16'h1000 + 16'(k * 4 + ir * 2 + tk);
            wr(OFF_SP, 32'h0);
            wr(OFF_SRC, 32'(w));
            op(16'h8D00);
            irq_pulse();
            wr(OFF_FLAGS, 32'(tk != 0 ? fy[k] : fn[k]));
            ip0 = instruction_pointer;
            op({nib[k], 4'hC, (ir != 0) ? 8'h8D : 8'h0D});
            chk("return ip", 32'(instruction_pointer), 32'(tk != 0 ? w : ip0 + 16'h1));
            rdchk("return sp", OFF_SP, 32'hFFFF_FFFF, 32'(tk != 0 ? 0 : 1));
            chk("return ins", 32'(interrupt_in_service_flag), 32'(!(ir != 0 && tk != 0)));
          end
        end
      end
    end
    $display("test return done");
  endtask

  task automatic t_bits;
    logic sup;
    for (int m = 0; m < 10; m++) begin
      sup = (m <= 5) || (m == 8);
      wr(OFF_MSEL, 32'(m));
      wr(OFF_MDATA, 32'h0);
      op({1'b1, 7'(m), 8'h97});
      op({1'b1, 7'(m), 8'hF7});
      rdchk("bit set", OFF_MDATA, 32'hFF, sup ? 32'h82 : 32'h0);
      op({1'b1, 7'(m), 8'h17});
      rdchk("bit clear", OFF_MDATA, 32'hFF, sup ? 32'h80 : 32'h0);
    end
    wr(OFF_FLAGS, 32'h0);
    op(16'hC887);
    op(16'hC8B7);
    op(16'hC897);
    rdchk("status bit set", OFF_FLAGS, 32'hF, 32'h9);
    op(16'hC807);
    rdchk("status bit clear", OFF_FLAGS, 32'hF, 32'h8);
    $display("test bits done");
  endtask

  task automatic t_cbit;
    wr(OFF_SRC, 32'hFFFD);
    wr(OFF_FLAGS, 32'h7);
    op(16'h1700);
    rdchk("copy bit 1", OFF_FLAGS, 32'hF, 32'h6);
    wr(OFF_SRC, 32'h8000);
    op(16'hF700);
    rdchk("copy bit 15", OFF_FLAGS, 32'hF, 32'h7);
    $display("test copy bit done");
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    irq_ack = 1'b0;
    num_errors = 0;
    num_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_carry();
    t_neg();
    t_or();
    t_orc();
    t_rot();
    t_stack();
    t_ret();
    t_bits();
    t_cbit();
    complete_run();
  end

  // cuts a hang short well beyond the thousand or so cycles the tests need
  initial begin
    #(25 * 40000);
    num_errors++;
    complete_run();
  end
endmodule // bsr_exec_tb_top
